// [flash_host_params.svh]
/*
 Constants of the NOR flash host controller: register map, field
 positions, flash command codes and bus timing.
 Assumes a 250 MHz clk_sys and a x16 flash on an asynchronous bus.
*/
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ADDR_SETUP_NS 10
`define T_WE_LOW_NS 35
`define T_WE_HIGH_NS 20
`define T_READ_ACC_NS 110
`define T_HV_SETTLE_NS 1000
`define T_TICK_NS 1000000
`define HV_LIMIT_HOURS 80
`define HV_LIMIT_MS (`HV_LIMIT_HOURS * 3600 * 1000)

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_CTRL 8'h08
`define REG_STATUS 8'h0c
`define REG_DATA 8'h10
`define REG_HVTIME 8'h14
`define CMD_OP_MSB 3
`define CTRL_WP_BIT 0
`define CTRL_FIX_BIT 1
`define ST_BUSY 0
`define ST_ERR 1
`define ST_SUSP 2
`define ST_REFUSED 3
`define ST_HV 4
`define ST_HV_SPENT 5
`define ST_RECOVER 6
`define ST_FAIL_LSB 16
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

// ----------------------------------------------------------------
// flash command codes and addresses
// ----------------------------------------------------------------
`define FC_UNLOCK1 8'haa
`define FC_UNLOCK2 8'h55
`define FC_ERASE_SETUP 8'h80
`define FC_ERASE_GO 8'h30
`define FC_AUTOSEL 8'h90
`define FC_BYPASS_EXIT 8'h00
`define FC_RESET 8'hf0
`define FC_SUSPEND 8'hb0
`define FC_BLANK_SETUP1 8'heb
`define FC_BLANK_SETUP2 8'h76
`define FC_BLANK_GO 8'h29
`define FA_UNLOCK1 25'h000_0555
`define FA_UNLOCK2 25'h000_02aa
`define FA_PROT_OFS 2
`define BLOCK_SHIFT 16
`define DQ_TOGGLE 6
`define DQ_FAIL 5
`endif

// [flash_host_pkg.sv]
/*
 Types of the NOR flash host controller: operation codes, sequence
 step kinds and address selectors.
 Assumes flash_host_params.svh for the numeric constants.
*/
package flash_host_pkg;

	// software operation codes
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_SUSPEND = 4'h2,
		OP_RESUME = 4'h3,
		OP_BLANK = 4'h4,
		OP_BERASE = 4'h5,
		OP_ACCEL = 4'h6,
		OP_PROT = 4'h7
	} op_t;

	typedef enum logic [1:0] {K_WR, K_RD, K_POLL, K_END} kind_t;

	typedef enum logic [2:0] {A_UNL1, A_UNL2, A_TGT, A_BLK, A_PROT} asel_t;

	typedef struct packed {
		kind_t kind;
		asel_t asel;
		logic [7:0] data;
	} step_t;

endpackage

// [flash_bus_cycle.sv]
/*
 One asynchronous flash bus cycle, write or read, timed in clk_sys
 cycles. Assumes the caller holds the request steady until cycDone.
*/
`timescale 1ns/10ps
`include "flash_host_params.svh"

module flash_bus_cycle
#(
	parameter int ADDR_W = 25,
	parameter int DATA_W = 16
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// request
	input wire logic start,
	input wire logic isWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqData,
	output logic cycDone,
	output logic [DATA_W-1:0] rdData,
	// flash pins
	output logic [ADDR_W-1:0] flashAddr,
	output logic [DATA_W-1:0] flashDqOut,
	output logic flashDqDriveN,
	input wire logic [DATA_W-1:0] flashDqIn,
	output logic flashCeN,
	output logic flashOeN,
	output logic flashWeN
);

	generate
		if (DATA_W < 8)
		begin : g_chk
			$error("flash_bus_cycle: DATA_W below 8");
		end
	endgenerate

	typedef enum {C_IDLE, C_SETUP, C_WE, C_HOLD, C_ACC, C_SAMPLE} cyc_t;
	cyc_t cyc_r;
	logic [7:0] cnt_r;
	logic [DATA_W-1:0] dqS1_r, dqS2_r, dqS3_r;

	// pin input synchroniser, stage one feeds stage two only
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		dqS1_r <= '0;
		dqS2_r <= '0;
		dqS3_r <= '0;
	end
	else
	begin
		dqS1_r <= flashDqIn;
		dqS2_r <= dqS1_r;
		dqS3_r <= dqS2_r;
	end

	// cycle sequencer and pin drive
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		cyc_r <= C_IDLE;
		cnt_r <= '0;
		cycDone <= 1'b0;
		rdData <= '0;
		flashAddr <= '0;
		flashDqOut <= '0;
		flashDqDriveN <= 1'b1;
		flashCeN <= 1'b1;
		flashOeN <= 1'b1;
		flashWeN <= 1'b1;
	end
	else
	begin
		cycDone <= 1'b0;
		case (cyc_r)
		C_IDLE:
			if (start)
			begin
				flashAddr <= reqAddr;
				flashCeN <= 1'b0;
				if (isWrite)
				begin
					flashDqOut <= reqData;
					flashDqDriveN <= 1'b0; // host drives dq
					cnt_r <= 8'(`CYC_UP(`T_ADDR_SETUP_NS) - 1);
					cyc_r <= C_SETUP;
				end
				else
				begin
					flashOeN <= 1'b0;
					cnt_r <= 8'(`CYC_UP(`T_READ_ACC_NS) - 1);
					cyc_r <= C_ACC;
				end
			end
		C_SETUP:
			if (cnt_r == 8'h00)
			begin
				flashWeN <= 1'b0;
				cnt_r <= 8'(`CYC_UP(`T_WE_LOW_NS) - 1);
				cyc_r <= C_WE;
			end
			else
				cnt_r <= cnt_r - 8'h01;
		C_WE:
			if (cnt_r == 8'h00)
			begin
				flashWeN <= 1'b1; // data latched on rising edge
				cnt_r <= 8'(`CYC_UP(`T_WE_HIGH_NS) - 1);
				cyc_r <= C_HOLD;
			end
			else
				cnt_r <= cnt_r - 8'h01;
		C_HOLD:
			if (cnt_r == 8'h00)
			begin
				flashCeN <= 1'b1;
				flashDqDriveN <= 1'b1;
				cycDone <= 1'b1;
				cyc_r <= C_IDLE;
			end
			else
				cnt_r <= cnt_r - 8'h01;
		C_ACC:
			if (cnt_r == 8'h00)
				cyc_r <= C_SAMPLE;
			else
				cnt_r <= cnt_r - 8'h01;
		C_SAMPLE:
			if (dqS2_r == dqS3_r) // settled value only
			begin
				rdData <= dqS3_r;
				flashCeN <= 1'b1;
				flashOeN <= 1'b1;
				cycDone <= 1'b1;
				cyc_r <= C_IDLE;
			end
		default:
			cyc_r <= C_IDLE;
		endcase
	end

endmodule // flash_bus_cycle

// [flash_erase_host.sv]
/*
 Host controller for a parallel NOR flash: erase, suspend/resume,
 accelerated chip erase with automatic repair, blank check and
 protection readout, ordered by software over AXI4-Lite.
 Assumes a flash on the pins below and a high-voltage switch that
 follows highVoltageLevel.
*/
// Implementation choices: the AXI4-Lite register port and the address map.
// Function
// [RQ1] halted erase leaves device in read mode, erase suspended
// [RQ2] during suspend only listed commands to other arrays accepted
// [RQ3] reading suspended block returns polling register
// [RQ4] program to protected or suspended block silently discarded
// [RQ5] exit autoselect, query, bypass, extended modes before resume
// [RQ6] suspend during chip erase ignored, chip erase continues
// [RQ7] one write of 30h resumes suspended block erase
// [RQ8] resume only in read-array mode; suspend/resume repeatable
// [RQ9] high voltage on protect pin enters bypass, 80/30h accepted
// [RQ10] accelerated erase skips protected, failed blocks; sets fail
// [RQ11] removing high voltage after erase leaves bypass mode
// [RQ12] after accelerated error, blank check then re-erase failures
// [RQ13] high voltage only during accelerated erase, under 80 hours; a spent budget refuses a new accelerated erase but does not end a running one
// [RQ14] blank check is EB/76h setup then 29h at target block
// [RQ15] blank check fails on programmed or over-erased cells
// [RQ16] each erase blank checks first, skipping blank blocks; OP_BERASE erases without a blank check, only the repair walk checks first
// [RQ17] blank check: one block, polling reads, others refused
// [RQ18] blank check pass returns read mode; error needs read/reset
// [RQ19] protect pin low guards boundary block; high follows software
// [RQ20] protection mode defaults nonvolatile, lock bits fix it
// [RQ21] program/erase to protected block ignored, back to read
// [RQ22] protection status readable in autoselect mode
// [RQ23] erase suspend is one write of B0h at any address
// [RQ24] autoselect protection status reads 00h or 01h
// [RQ25] poll status to completion or error before next command
`timescale 1ns/10ps
`include "flash_host_params.svh"

module flash_erase_host
	import flash_host_pkg::*;
#(
	parameter int ADDR_W = 25,
	parameter int NUM_BLOCKS = 512,
	parameter int TICK_CYCLES = `CYC_UP(`T_TICK_NS),
	parameter int HV_LIMIT_MS = `HV_LIMIT_MS
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// flash pins
	output logic [ADDR_W-1:0] flashAddr,
	output logic [15:0] flashDqOut,
	output logic flashDqDriveN,
	input wire logic [15:0] flashDqIn,
	output logic flashCeN,
	output logic flashOeN,
	output logic flashWeN,
	output logic vppWpHigh,
	output logic highVoltageLevel
);

	localparam int BLK_W = $clog2(NUM_BLOCKS);

	generate
		if (BLK_W + `BLOCK_SHIFT > ADDR_W || NUM_BLOCKS < 2)
		begin : g_chk
			$error("flash_erase_host: block count does not fit address");
		end
	endgenerate

	typedef enum {S_IDLE, S_HVUP, S_ISSUE, S_WAIT, S_HVDOWN} state_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic mapped(input logic [7:0] a);
		mapped = a[7:2] <= `REG_HVTIME >> 2;
	endfunction

	function automatic step_t wr(input asel_t s, input logic [7:0] d);
		wr = '{K_WR, s, d};
	endfunction

	// command sequence of each operation, one bus step per index
	function automatic step_t seqStep(input op_t op, input logic [3:0] i);
		step_t s;
		s = '{K_END, A_TGT, 8'h00};
		if ((op == OP_BERASE || op == OP_PROT) && i == 4'h0)
			s = wr(A_UNL1, `FC_UNLOCK1);
		else if ((op == OP_BERASE || op == OP_PROT) && i == 4'h1)
			s = wr(A_UNL2, `FC_UNLOCK2);
		else
			case (op)
			OP_READ: if (i == 4'h0) s = '{K_RD, A_TGT, 8'h00};
			OP_RESET: if (i == 4'h0) s = wr(A_TGT, `FC_RESET);
			OP_BERASE:
				case (i)
				4'h2: s = wr(A_UNL1, `FC_ERASE_SETUP);
				4'h3: s = wr(A_UNL1, `FC_UNLOCK1);
				4'h4: s = wr(A_UNL2, `FC_UNLOCK2);
				4'h5: s = wr(A_BLK, `FC_ERASE_GO);
				4'h6: s = '{K_POLL, A_BLK, 8'h00}; // [RQ25]
				default: s = '{K_END, A_TGT, 8'h00};
				endcase
			OP_PROT: // [RQ22] [RQ24]
				case (i)
				4'h2: s = wr(A_UNL1, `FC_AUTOSEL);
				4'h3: s = '{K_RD, A_PROT, 8'h00};
				4'h4: s = wr(A_TGT, `FC_RESET);
				default: s = '{K_END, A_TGT, 8'h00};
				endcase
			OP_RESUME:
				case (i)
				4'h0: s = wr(A_TGT, `FC_RESET); // [RQ5]
				4'h1: s = wr(A_TGT, `FC_AUTOSEL); // [RQ5]
				4'h2: s = wr(A_TGT, `FC_BYPASS_EXIT); // [RQ5]
				4'h3: s = wr(A_TGT, `FC_ERASE_GO); // [RQ7] [RQ8]
				4'h4: s = '{K_POLL, A_BLK, 8'h00};
				default: s = '{K_END, A_TGT, 8'h00};
				endcase
			OP_BLANK:
				case (i)
				4'h0: s = wr(A_BLK, `FC_BLANK_SETUP1); // [RQ14]
				4'h1: s = wr(A_BLK, `FC_BLANK_SETUP2); // [RQ14]
				4'h2: s = wr(A_BLK, `FC_BLANK_GO); // [RQ14]
				4'h3: s = '{K_POLL, A_BLK, 8'h00};
				default: s = '{K_END, A_TGT, 8'h00};
				endcase
			OP_ACCEL:
				case (i)
				4'h0: s = wr(A_UNL1, `FC_ERASE_SETUP); // [RQ9]
				4'h1: s = wr(A_UNL1, `FC_ERASE_GO); // [RQ9]
				4'h2: s = '{K_POLL, A_UNL1, 8'h00};
				default: s = '{K_END, A_TGT, 8'h00};
				endcase
			default: s = '{K_END, A_TGT, 8'h00};
			endcase
		return s;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t state_r;
	op_t curOp_r;
	step_t step;
	logic [3:0] stepIdx_r;
	logic [ADDR_W-1:0] tgtAddr_r, effTgt, blkBase, stepAddr;
	logic wpHigh_r, autoFix_r, err_r, accelErr_r, suspended_r, refused_r;
	logic recovering_r, eraseNext_r, suspendReq_r, suspSent_r, b0Issue;
	logic pollFirst_r, pollConfirm_r, cycWr_r, isB0_r, cycStart_r;
	logic cycDone;
	logic [15:0] cycData_r, cycRd, rdData_r, pollPrev_r;
	logic [ADDR_W-1:0] cycAddr_r;
	logic [BLK_W-1:0] blk_r;
	logic [BLK_W:0] failCnt_r;
	logic [9:0] settle_r;
	logic [31:0] tickCnt_r, hvMs_r;
	logic hvSpent, busy, cmdWr, cmdOk, startCmd;
	logic awHave_r, wHave_r, wrEn;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	op_t cmdOp;

	assign step = seqStep(curOp_r, stepIdx_r);
	assign effTgt = recovering_r ?
		ADDR_W'({blk_r, {`BLOCK_SHIFT{1'b0}}}) : tgtAddr_r;
	assign blkBase = {effTgt[ADDR_W-1:`BLOCK_SHIFT],
		{`BLOCK_SHIFT{1'b0}}};

	// address of the current step
	always_comb
	begin
		case (step.asel)
		A_UNL1: stepAddr = ADDR_W'(`FA_UNLOCK1);
		A_UNL2: stepAddr = ADDR_W'(`FA_UNLOCK2);
		A_BLK: stepAddr = blkBase;
		A_PROT: stepAddr = blkBase | ADDR_W'(`FA_PROT_OFS);
		default: stepAddr = effTgt;
		endcase
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	assign awready = !awHave_r && !bvalid;
	assign wready = !wHave_r && !bvalid;
	assign arready = !rvalid;
	assign wrEn = awHave_r && wHave_r && !bvalid;

	// write address/data capture and response
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		awHave_r <= 1'b0;
		wHave_r <= 1'b0;
		awAddr_r <= '0;
		wData_r <= '0;
		wStrb_r <= '0;
		bvalid <= 1'b0;
		bresp <= `AXI_OKAY;
	end
	else
	begin
		if (awvalid && awready)
		begin
			awHave_r <= 1'b1;
			awAddr_r <= awaddr;
		end
		if (wvalid && wready)
		begin
			wHave_r <= 1'b1;
			wData_r <= wdata;
			wStrb_r <= wstrb;
		end
		if (wrEn)
		begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			bvalid <= 1'b1;
			bresp <= mapped(awAddr_r) ? `AXI_OKAY : `AXI_SLVERR;
		end
		else if (bvalid && bready)
			bvalid <= 1'b0;
	end

	// read response
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		rvalid <= 1'b0;
		rdata <= '0;
		rresp <= `AXI_OKAY;
	end
	else if (arvalid && arready)
	begin
		rvalid <= 1'b1;
		rresp <= mapped(araddr) ? `AXI_OKAY : `AXI_SLVERR;
		case (araddr[7:2])
		`REG_CMD >> 2: rdata <= 32'(curOp_r);
		`REG_ADDR >> 2: rdata <= 32'(tgtAddr_r);
		`REG_CTRL >> 2: rdata <= 32'({autoFix_r, wpHigh_r});
		`REG_STATUS >> 2: rdata <= 32'({failCnt_r,
			{(`ST_FAIL_LSB - `ST_RECOVER - 1){1'b0}}, recovering_r,
			hvSpent, highVoltageLevel, refused_r, suspended_r,
			err_r | accelErr_r, busy});
		`REG_DATA >> 2: rdata <= 32'(rdData_r);
		`REG_HVTIME >> 2: rdata <= hvMs_r;
		default: rdata <= 32'h0000_0000;
		endcase
	end
	else if (rvalid && rready)
		rvalid <= 1'b0;

	// ----------------------------------------------------------------
	// software registers and command acceptance
	// ----------------------------------------------------------------
	assign busy = state_r != S_IDLE;
	assign cmdWr = wrEn && awAddr_r[7:2] == `REG_CMD >> 2 && wStrb_r[0];
	assign cmdOp = op_t'(wData_r[`CMD_OP_MSB:0]);
	assign vppWpHigh = wpHigh_r; // [RQ19]

	always_comb
	begin
		case (cmdOp)
		OP_SUSPEND: // [RQ6] [RQ23] block erase only
			cmdOk = busy && !recovering_r && !suspSent_r &&
				(curOp_r == OP_BERASE || curOp_r == OP_RESUME);
		OP_RESUME: cmdOk = !busy && suspended_r; // [RQ8]
		OP_READ, OP_RESET, OP_PROT: cmdOk = !busy;
		OP_ACCEL: cmdOk = !busy && !suspended_r && !hvSpent; // [RQ13]
		OP_BLANK, OP_BERASE: cmdOk = !busy && !suspended_r; // [RQ25]
		default: cmdOk = 1'b0;
		endcase
	end
	assign startCmd = cmdWr && cmdOk && cmdOp != OP_SUSPEND;

	// address, control and refusal flag
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		tgtAddr_r <= '0;
		wpHigh_r <= 1'b0;
		autoFix_r <= 1'b0;
		refused_r <= 1'b0;
	end
	else if (wrEn)
	begin
		if (awAddr_r[7:2] == `REG_ADDR >> 2 && !busy)
			tgtAddr_r <= wData_r[ADDR_W-1:0];
		if (awAddr_r[7:2] == `REG_CTRL >> 2 && wStrb_r[0])
		begin
			wpHigh_r <= wData_r[`CTRL_WP_BIT];
			autoFix_r <= wData_r[`CTRL_FIX_BIT];
		end
		if (cmdWr)
			refused_r <= !cmdOk;
	end

	// pending suspend request; a new request wins over the clear
	assign b0Issue = state_r == S_ISSUE && step.kind == K_POLL &&
		suspendReq_r;
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
		suspendReq_r <= 1'b0;
	else if (cmdWr && cmdOk && cmdOp == OP_SUSPEND)
		suspendReq_r <= 1'b1;
	else if (b0Issue || !busy)
		suspendReq_r <= 1'b0;

	// high-voltage time budget in millisecond ticks
	assign hvSpent = hvMs_r >= 32'(HV_LIMIT_MS);
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		tickCnt_r <= '0;
		hvMs_r <= '0;
	end
	else if (highVoltageLevel)
	begin
		if (tickCnt_r == 32'(TICK_CYCLES - 1))
		begin
			tickCnt_r <= '0;
			if (!hvSpent)
				hvMs_r <= hvMs_r + 32'h0000_0001; // [RQ13]
		end
		else
			tickCnt_r <= tickCnt_r + 32'h0000_0001;
	end

	// ----------------------------------------------------------------
	// operation sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset)
	if (reset)
	begin
		state_r <= S_IDLE;
		curOp_r <= OP_READ;
		stepIdx_r <= '0;
		err_r <= 1'b0;
		accelErr_r <= 1'b0;
		suspended_r <= 1'b0;
		recovering_r <= 1'b0;
		eraseNext_r <= 1'b0;
		suspSent_r <= 1'b0;
		pollFirst_r <= 1'b1;
		pollConfirm_r <= 1'b0;
		pollPrev_r <= '0;
		rdData_r <= '0;
		blk_r <= '0;
		failCnt_r <= '0;
		highVoltageLevel <= 1'b0;
		settle_r <= '0;
		cycStart_r <= 1'b0;
		cycWr_r <= 1'b0;
		isB0_r <= 1'b0;
		cycAddr_r <= '0;
		cycData_r <= '0;
	end
	else
	begin
		cycStart_r <= 1'b0;
		case (state_r)
		S_IDLE:
			if (startCmd)
			begin
				curOp_r <= cmdOp;
				stepIdx_r <= '0;
				err_r <= 1'b0;
				accelErr_r <= 1'b0;
				suspSent_r <= 1'b0;
				pollFirst_r <= 1'b1;
				pollConfirm_r <= 1'b0;
				if (cmdOp == OP_RESUME)
					suspended_r <= 1'b0; // [RQ8]
				if (cmdOp == OP_ACCEL)
				begin
					highVoltageLevel <= 1'b1; // [RQ9] [RQ13]
					failCnt_r <= '0;
					settle_r <= 10'(`CYC_UP(`T_HV_SETTLE_NS) - 1);
					state_r <= S_HVUP;
				end
				else
					state_r <= S_ISSUE;
			end
		S_HVUP:
			if (settle_r == 10'h000)
				state_r <= S_ISSUE;
			else
				settle_r <= settle_r - 10'h001;
		S_ISSUE:
			if (step.kind != K_END)
			begin
				cycStart_r <= 1'b1;
				cycWr_r <= step.kind == K_WR || b0Issue;
				isB0_r <= b0Issue;
				cycAddr_r <= b0Issue ? tgtAddr_r : stepAddr; // [RQ23]
				cycData_r <= 16'(b0Issue ? `FC_SUSPEND : step.data);
				if (b0Issue)
					suspSent_r <= 1'b1;
				state_r <= S_WAIT;
			end
			else if (curOp_r == OP_ACCEL)
			begin
				highVoltageLevel <= 1'b0; // [RQ11] [RQ13]
				settle_r <= 10'(`CYC_UP(`T_HV_SETTLE_NS) - 1);
				state_r <= S_HVDOWN;
			end
			else if (!recovering_r)
				state_r <= S_IDLE;
			else
			begin
				// repair walk over all blocks
				stepIdx_r <= '0;
				pollFirst_r <= 1'b1;
				pollConfirm_r <= 1'b0;
				if (curOp_r == OP_RESET)
					curOp_r <= eraseNext_r ? OP_BERASE : OP_BLANK;
				else if (curOp_r == OP_BLANK && err_r)
				begin
					failCnt_r <= failCnt_r + 1'b1; // [RQ12]
					err_r <= 1'b0;
					eraseNext_r <= 1'b1;
					curOp_r <= OP_RESET; // [RQ18]
				end
				else if (blk_r == BLK_W'(NUM_BLOCKS - 1))
				begin
					recovering_r <= 1'b0;
					err_r <= 1'b0;
					curOp_r <= OP_RESET;
					eraseNext_r <= 1'b0;
				end
				else
				begin
					blk_r <= blk_r + 1'b1;
					eraseNext_r <= 1'b0;
					curOp_r <= (curOp_r == OP_BERASE) ? OP_RESET : OP_BLANK;
				end
			end
		S_WAIT:
			if (cycDone)
			begin
				state_r <= S_ISSUE;
				if (cycWr_r)
				begin
					if (!isB0_r)
						stepIdx_r <= stepIdx_r + 4'h1;
				end
				else if (step.kind == K_RD)
				begin
					rdData_r <= cycRd;
					stepIdx_r <= stepIdx_r + 4'h1;
				end
				else if (pollFirst_r)
				begin
					pollPrev_r <= cycRd;
					pollFirst_r <= 1'b0;
				end
				else if (cycRd[`DQ_TOGGLE] == pollPrev_r[`DQ_TOGGLE])
				begin
					stepIdx_r <= stepIdx_r + 4'h1; // [RQ25]
					suspended_r <= suspSent_r;
				end
				else if (pollConfirm_r)
				begin
					err_r <= 1'b1; // [RQ10]
					stepIdx_r <= stepIdx_r + 4'h1;
				end
				else if (cycRd[`DQ_FAIL])
				begin
					pollConfirm_r <= 1'b1;
					pollFirst_r <= 1'b1;
				end
				else
					pollPrev_r <= cycRd;
			end
		S_HVDOWN:
			if (settle_r != 10'h000)
				settle_r <= settle_r - 10'h001;
			else if (err_r)
			begin
				accelErr_r <= 1'b1; // [RQ10]
				state_r <= autoFix_r ? S_ISSUE : S_IDLE;
				if (autoFix_r)
				begin
					recovering_r <= 1'b1; // [RQ12]
					blk_r <= '0;
					eraseNext_r <= 1'b0;
					err_r <= 1'b0;
					curOp_r <= OP_RESET;
					stepIdx_r <= '0;
				end
			end
			else
				state_r <= S_IDLE;
		default:
			state_r <= S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// bus cycle engine
	// ----------------------------------------------------------------
	flash_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(16)) u_cycle (
		.clk_sys(clk_sys),
		.reset(reset),
		.start(cycStart_r),
		.isWrite(cycWr_r),
		.reqAddr(cycAddr_r),
		.reqData(cycData_r),
		.cycDone(cycDone),
		.rdData(cycRd),
		.flashAddr(flashAddr),
		.flashDqOut(flashDqOut),
		.flashDqDriveN(flashDqDriveN),
		.flashDqIn(flashDqIn),
		.flashCeN(flashCeN),
		.flashOeN(flashOeN),
		.flashWeN(flashWeN)
	);

endmodule // flash_erase_host

// [flash_erase_host_sva.sv]
/*
 checker of flash_erase_host: axi answers and flash strobes.
 assumes binding to the host's top-level ports.
*/
`timescale 1ns/10ps
module flash_erase_host_sva
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// axi handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [1:0] rresp,
	// flash strobes
	input wire logic flashCeN,
	input wire logic flashOeN,
	input wire logic flashWeN
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// write pulse and read access shapes
	sequence weHeld; (!flashWeN)[*8] ##1 flashWeN; endsequence
	sequence oeHeld; !flashCeN ##1 (!flashOeN)[*8]; endsequence
	write_resp_a: assert property
		(awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("no b");
	resp_hold_a: assert property
		(bvalid && !bready |=> bvalid) else $error("b dropped");
	read_resp_a: assert property
		(arvalid && arready |=> rvalid) else $error("no r");
	read_hold_a: assert property
		(rvalid && !rready |=> rvalid && $stable(rresp)) else $error("r moved");
	unmapped_read_a: assert property
		(arvalid && arready && araddr >= 8'h18 |=> rresp == 2'h2)
		else $error("no slverr");
	we_strobe_a: assert property
		(!flashWeN |-> !flashCeN && flashOeN) else $error("bad strobes");
	we_pulse_a: assert property
		($fell(flashWeN) |=> weHeld) else $error("bad we width");
	oe_access_a: assert property
		($fell(flashOeN) |-> oeHeld) else $error("short read");
endmodule // flash_erase_host_sva
bind flash_erase_host flash_erase_host_sva chk (.*);

// [flash_dev_model.sv]
/*
 behavioural x16 nor flash: erase, suspend, resume, blank check,
 autoselect protection and polling. assumes the bench resolves dq.
*/
`timescale 1ns/10ps
module flash_dev_model
(
	// flash pins
	input wire logic [24:0] flashAddr,
	input wire logic [15:0] flashDqOut,
	input wire logic flashCeN,
	input wire logic flashOeN,
	input wire logic flashWeN,
	input wire logic vppWpHigh,
	input wire logic highVoltageLevel,
	output logic [15:0] devDq
);
	int busy = 0;
	logic susp = 0, err = 0, tog = 0, aut = 0, arm = 0;
	logic [7:0] prev = 8'h00;
	logic [8:0] sBlk = 9'h000;
	logic [15:0] last = 16'h0000;
	wire logic [8:0] blk = flashAddr[24:16];
	wire logic prot = blk == 9'h000 && !vppWpHigh;
	// command decode on the rising write strobe
	always @(posedge flashWeN)
	begin
		if (!flashCeN)
		begin
			case (flashDqOut[7:0])
			8'hf0: {aut, err, arm} = 3'b000;
			8'h80: arm = 1'b1;
			8'h90: aut = 1'b1;
			8'h00: aut = 1'b0;
			8'hb0: if (busy > 0 && !highVoltageLevel)
			begin
				susp = 1'b1;
				busy = 0;
			end
			8'h30: if (susp && !aut)
			begin
				susp = 1'b0;
				busy = 6;
			end
			else if (arm && (highVoltageLevel || !prot))
			begin
				busy = 6;
				sBlk = blk;
			end
			8'h29: if (prev == 8'h76)
			begin
				busy = 2;
				err = blk == 9'h002;
			end
			default: ;
			endcase
			prev = flashDqOut[7:0];
		end
	end
	// polling toggles once per read while busy or failed
	always @(negedge flashOeN)
	begin
		if (!flashCeN && (busy > 0 || err))
		begin
			tog = !tog;
			busy = busy > 0 ? busy - 1 : 0;
		end
	end
	// released lines show the inverse of the last value
	always @(devDq) if (!flashOeN && !flashCeN) last = ~devDq;
	assign devDq = (flashOeN || flashCeN) ? last
		: (busy > 0 || err || susp && blk == sBlk) ? {9'h000, tog, err, 5'h00}
		: (aut && flashAddr[1:0] == 2'h2) ? {15'h0000, prot}
		: 16'hffff;
endmodule // flash_dev_model

// [flash_erase_host_tb_top.sv]
/*
 self-checking bench of flash_erase_host with a behavioural flash.
 assumes flash_dev_model and the bound checker.
*/
`timescale 1ns/10ps
`include "flash_host_params.svh"
module flash_erase_host_tb_top;
	import flash_host_pkg::*;
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	err_total++; $display("unexpected %s exp %h got %h", n, e, s); end end
	logic clk_sys, reset, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, flashDqDriveN, flashCeN;
	logic flashOeN, flashWeN, vppWpHigh, highVoltageLevel;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, br, rr;
	logic [24:0] flashAddr;
	logic [15:0] flashDqOut, flashDqIn, devDq;
	int err_total = 0, samples_checked = 0;
	typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} row_t;
	row_t rows [4] = '{'{`REG_ADDR, 32'h0001_0000, 32'h0001_0000, `AXI_OKAY},
		'{`REG_CTRL, 32'h0000_0003, 32'h0000_0003, `AXI_OKAY},
		'{8'h18, 32'h0000_00ff, 32'h0000_0000, `AXI_SLVERR},
		'{8'hfc, 32'h0000_00ff, 32'h0000_0000, `AXI_SLVERR}};
	flash_erase_host #(.NUM_BLOCKS(4), .TICK_CYCLES(10), .HV_LIMIT_MS(3)) uut (.*);
	flash_dev_model dev (.*);
	// shared dq wire
	assign flashDqIn = flashDqDriveN ? devDq : flashDqOut;
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic complete_run();
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stuck();
		err_total++;
		complete_run();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		for (n = 0; n < 50 && bvalid !== 1'b1; n++)
		begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		br = bresp;
		bready <= 1'b0;
		if (n == 50) stuck();
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clk_sys);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		for (n = 0; n < 50 && rvalid !== 1'b1; n++)
		begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end
		{rv, rr} = {rdata, rresp};
		rready <= 1'b0;
		if (n == 50) stuck();
	endtask
	task automatic op(input op_t o);
		wr(`REG_CMD, 32'(o));
	endtask
	task automatic idle();
		int n;
		for (n = 0; n < 1000; n++)
		begin
			rd(`REG_STATUS);
			if (rv[`ST_BUSY] === 1'b0) break;
		end
		if (n == 1000) stuck();
	endtask
	// main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, reset} <= 6'h01;
		{awaddr, araddr, wdata, wstrb} <= {16'h0000, 32'h0000_0000, 4'hf};
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			`CHK("bresp", rows[i].r, br)
			rd(rows[i].a);
			`CHK("rdata", rows[i].e, rv)
			`CHK("rresp", rows[i].r, rr)
		end
		// erase suspended, resumed, resume refused
		op(OP_BERASE);
		op(OP_SUSPEND);
		idle();
		`CHK("suspend", 4'b0100, rv[3:0])
		op(OP_BLANK);
		rd(`REG_STATUS);
		`CHK("blank refused", 1'b1, rv[`ST_REFUSED])
		op(OP_RESUME);
		idle();
		`CHK("resume", 4'b0000, rv[3:0])
		op(OP_RESUME);
		rd(`REG_STATUS);
		`CHK("resume refused", 1'b1, rv[`ST_REFUSED])
		// blank check failing, reset, then passing
		wr(`REG_ADDR, 32'h0002_0000);
		op(OP_BLANK);
		idle();
		`CHK("blank fail", 1'b1, rv[`ST_ERR])
		op(OP_RESET);
		idle();
		wr(`REG_ADDR, 32'h0003_0000);
		op(OP_BLANK);
		idle();
		`CHK("blank pass", 1'b0, rv[`ST_ERR])
		// boundary block status against the protect pin
		wr(`REG_ADDR, 32'h0000_0000);
		for (int w = 0; w < 2; w++)
		begin
			wr(`REG_CTRL, 32'(w));
			op(OP_PROT);
			idle();
			rd(`REG_DATA);
			`CHK("protect pin", w[0], vppWpHigh)
			`CHK("protect status", 16'(1 - w), rv[15:0])
		end
		// accelerated erase spends the high-voltage budget
		op(OP_ACCEL);
		idle();
		`CHK("high voltage off", 1'b0, highVoltageLevel)
		op(OP_ACCEL);
		rd(`REG_STATUS);
		`CHK("budget", 2'b11, {rv[`ST_HV_SPENT], rv[`ST_REFUSED]})
		// second reset clears control
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		rd(`REG_CTRL);
		`CHK("ctrl reset", 32'h0000_0000, rv)
		`CHK("pin reset", 1'b0, vppWpHigh)
		complete_run();
	end
endmodule // flash_erase_host_tb_top
